// ==== common/supervision_pkg.sv ====
// constants, carriers and helper functions for the measuring circuit supervision
// Behaviour
// RULE_01: the mismatch is the phasor sum of the three phase currents plus the earth current scaled by the earth ratio factor, and its magnitude is evaluated.
// RULE_02: the earth ratio factor comes from the programmed primary and secondary ratings of the phase and earth transformers, with no setting of its own.
// RULE_03: the limit is the base deviation threshold plus the dynamic correction factor times the largest phase current.
// RULE_04: the dynamic correction factor lets the limit grow linearly with load to cover a current proportional measuring error.
// RULE_05: a transformer failure alarm is raised whenever the mismatch magnitude is greater than or equal to the limit.
// RULE_06: software should disable the failure supervision when only two phases or no separate earth current are measured.
// RULE_07: each measuring input is judged forward or reverse from its positive and negative sequence components.
// RULE_08: each input's rotation is compared with the programmed rotation and each current or voltage input has its own warning flag.
// RULE_09: rotation is judged only when the input reaches one tenth of its rated value.
// RULE_10: the largest phase current is taken from the same evaluation sample as the mismatch.
// RULE_11: the failure alarm follows the condition and drops once the mismatch falls below the limit.
package supervision_pkg;

  // measuring inputs judged for rotation: two current sets and one voltage set
  localparam int NUM_CT = 2;
  localparam int NUM_IN = 3;

  localparam int PH_W = 16;
  localparam int RAT_W = 16;
  localparam int WIDE_W = 52;
  localparam int MAG_W = 53;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] CTRL_OFFS = 8'h00;
  localparam logic [7:0] BASE_DEV_OFFS = 8'h04;
  localparam logic [7:0] DYN_CORR_OFFS = 8'h08;
  localparam logic [7:0] PH_PRI_OFFS = 8'h0c;
  localparam logic [7:0] PH_SEC_OFFS = 8'h10;
  localparam logic [7:0] E_PRI_OFFS = 8'h14;
  localparam logic [7:0] E_SEC_OFFS = 8'h18;
  localparam logic [7:0] CT_RATED_OFFS = 8'h1c;
  localparam logic [7:0] VT_RATED_OFFS = 8'h20;
  localparam logic [7:0] STATUS_OFFS = 8'h24;
  localparam logic [7:0] IRQ_STAT_OFFS = 8'h28;
  localparam logic [7:0] IRQ_MASK_OFFS = 8'h2c;
  localparam logic [7:0] LIMIT_OFFS = 8'h30;
  localparam logic [7:0] IMAX_OFFS = 8'h34;

  // field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_REVERSE_BIT = 1;
  localparam int STAT_ALARM_BIT = 0;
  localparam int STAT_WARN_LSB = 1;
  localparam int STAT_FWD_LSB = 8;
  localparam int EVT_W = 1 + NUM_IN;

  // reset values
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [15:0] BASE_DEV_RESET = 16'h0100;
  localparam logic [7:0] DYN_CORR_RESET = 8'h00;
  localparam logic [15:0] RATIO_RESET = 16'h0001;
  localparam logic [15:0] RATED_RESET = 16'h1000;

  // dynamic correction factor is an unsigned fraction of 2^KD_FRAC
  localparam int KD_FRAC = 8;
  // rated value divided by this gives the least level for a rotation verdict
  localparam logic [3:0] LEVEL_DIV = 4'ha;

  typedef struct packed {
    logic signed [PH_W-1:0] re;
    logic signed [PH_W-1:0] im;
  } phasor_type;

  typedef struct packed {
    phasor_type ph1;
    phasor_type ph2;
    phasor_type ph3;
    phasor_type earth;
  } cts_sample_type;

  typedef struct packed {
    logic [PH_W-1:0] pos;
    logic [PH_W-1:0] neg;
  } seq_type;

  // magnitude estimate: larger part plus half the smaller (within about 12 %)
  function automatic logic [MAG_W-1:0] mag_est(input logic signed [WIDE_W-1:0] re,
                                               input logic signed [WIDE_W-1:0] im);
    logic [WIDE_W-1:0] a;
    logic [WIDE_W-1:0] b;
    a = re[WIDE_W-1] ? WIDE_W'(-re) : WIDE_W'(re);
    b = im[WIDE_W-1] ? WIDE_W'(-im) : WIDE_W'(im);
    if (a >= b) begin
      mag_est = {1'b0, a} + MAG_W'(b >> 1);
    end else begin
      mag_est = {1'b0, b} + MAG_W'(a >> 1);
    end
  endfunction

endpackage

// ==== logic/meas_supervision.sv ====
// transformer failure and rotation supervision with its register port
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module meas_supervision (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [supervision_pkg::ADDR_W-1:0] addr_i,
  input wire logic [supervision_pkg::DATA_W-1:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [supervision_pkg::DATA_W-1:0] rd_data_o,
  // phasor samples of the phase and earth currents
  input wire logic sample_valid_i,
  input wire supervision_pkg::cts_sample_type sample_i,
  // sequence components of every measuring input
  input wire logic seq_valid_i,
  input wire supervision_pkg::seq_type [supervision_pkg::NUM_IN-1:0] seq_i,
  // indications
  output logic alarm_o,
  output logic [supervision_pkg::NUM_IN-1:0] warn_o,
  output logic irq_o
);

  localparam int PW = supervision_pkg::PH_W;
  localparam int WW = supervision_pkg::WIDE_W;
  localparam int MW = supervision_pkg::MAG_W;
  localparam int NI = supervision_pkg::NUM_IN;
  localparam int EW = supervision_pkg::EVT_W;

  // software registers
  logic [1:0] ctrl_r;
  logic [15:0] base_dev_r;
  logic [7:0] dyn_corr_r;
  logic [15:0] ph_pri_r;
  logic [15:0] ph_sec_r;
  logic [15:0] e_pri_r;
  logic [15:0] e_sec_r;
  logic [15:0] ct_rated_r;
  logic [15:0] vt_rated_r;
  logic [EW-1:0] irq_stat_r;
  logic [EW-1:0] irq_mask_r;

  // evaluation pipeline
  logic stage1_r;
  logic stage2_r;
  logic signed [PW+1:0] sum_re_r;
  logic signed [PW+1:0] sum_im_r;
  supervision_pkg::phasor_type earth_r;
  logic [PW:0] imax_r;
  logic signed [WW-1:0] mis_re_r;
  logic signed [WW-1:0] mis_im_r;
  logic [MW-1:0] limit_sc_r;
  logic [PW+1:0] limit_r;
  logic alarm_r;

  // rotation results and edge tracking
  logic [NI-1:0] fwd;
  logic [NI-1:0] warn;
  logic [EW-1:0] evt_prev_r;
  logic [EW-1:0] evt_now;
  logic [EW-1:0] evt_rise;

  // combinational helpers
  logic wr_hit;
  logic [WW-1:0] mag1;
  logic [WW-1:0] mag2;
  logic [WW-1:0] mag3;
  logic [PW:0] imax_nxt;
  logic [32:0] ph_scale;
  logic [32:0] e_scale;
  logic [PW+1:0] limit_nxt;
  logic [MW-1:0] mis_mag;
  logic [supervision_pkg::DATA_W-1:0] rd_nxt;

  assign wr_hit = wr_i;

  // control and settings, written whole words with the low bits kept
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= supervision_pkg::CTRL_RESET;
      base_dev_r <= supervision_pkg::BASE_DEV_RESET;
      dyn_corr_r <= supervision_pkg::DYN_CORR_RESET;
    end else if (wr_hit) begin
      case (addr_i)
        supervision_pkg::CTRL_OFFS: begin
          ctrl_r <= wr_data_i[1:0]; // RULE_06
        end
        supervision_pkg::BASE_DEV_OFFS: begin
          base_dev_r <= wr_data_i[15:0];
        end
        supervision_pkg::DYN_CORR_OFFS: begin
          dyn_corr_r <= wr_data_i[7:0];
        end
        default: begin
          ctrl_r <= ctrl_r;
        end
      endcase
    end
  end

  // transformer ratings; zero is refused so the scale factors never vanish
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ph_pri_r <= supervision_pkg::RATIO_RESET;
      ph_sec_r <= supervision_pkg::RATIO_RESET;
      e_pri_r <= supervision_pkg::RATIO_RESET;
      e_sec_r <= supervision_pkg::RATIO_RESET;
      ct_rated_r <= supervision_pkg::RATED_RESET;
      vt_rated_r <= supervision_pkg::RATED_RESET;
    end else if (wr_hit && wr_data_i[15:0] != 16'h0000) begin
      case (addr_i)
        supervision_pkg::PH_PRI_OFFS: begin
          ph_pri_r <= wr_data_i[15:0];
        end
        supervision_pkg::PH_SEC_OFFS: begin
          ph_sec_r <= wr_data_i[15:0];
        end
        supervision_pkg::E_PRI_OFFS: begin
          e_pri_r <= wr_data_i[15:0];
        end
        supervision_pkg::E_SEC_OFFS: begin
          e_sec_r <= wr_data_i[15:0];
        end
        supervision_pkg::CT_RATED_OFFS: begin
          ct_rated_r <= wr_data_i[15:0];
        end
        supervision_pkg::VT_RATED_OFFS: begin
          vt_rated_r <= wr_data_i[15:0];
        end
        default: begin
          ph_pri_r <= ph_pri_r;
        end
      endcase
    end
  end

  // phase magnitudes of the current sample
  assign mag1 = WW'(supervision_pkg::mag_est(WW'(sample_i.ph1.re), WW'(sample_i.ph1.im)));
  assign mag2 = WW'(supervision_pkg::mag_est(WW'(sample_i.ph2.re), WW'(sample_i.ph2.im)));
  assign mag3 = WW'(supervision_pkg::mag_est(WW'(sample_i.ph3.re), WW'(sample_i.ph3.im)));

  // largest phase current of this very sample
  always_comb begin
    imax_nxt = mag1[PW:0];
    if (mag2[PW:0] > imax_nxt) begin
      imax_nxt = mag2[PW:0];
    end
    if (mag3[PW:0] > imax_nxt) begin
      imax_nxt = mag3[PW:0];
    end
  end

  // stage 1: phasor sum and maximum, both from the same sample
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stage1_r <= 1'b0;
      sum_re_r <= '0;
      sum_im_r <= '0;
      earth_r <= '0;
      imax_r <= '0;
    end else begin
      stage1_r <= sample_valid_i;
      if (sample_valid_i) begin
        sum_re_r <= (PW+2)'(sample_i.ph1.re) + (PW+2)'(sample_i.ph2.re)
                    + (PW+2)'(sample_i.ph3.re); // RULE_01
        sum_im_r <= (PW+2)'(sample_i.ph1.im) + (PW+2)'(sample_i.ph2.im)
                    + (PW+2)'(sample_i.ph3.im); // RULE_01
        earth_r <= sample_i.earth;
        imax_r <= imax_nxt; // RULE_10
      end
    end
  end

  // earth ratio correction by cross multiplication, which needs no divider:
  // phase sum scaled by ph_pri*e_sec, earth by e_pri*ph_sec
  assign ph_scale = {1'b0, 32'(ph_pri_r * e_sec_r)}; // RULE_02
  assign e_scale = {1'b0, 32'(e_pri_r * ph_sec_r)}; // RULE_02

  // limit in phase secondary units, Kd a fraction of 2^8
  assign limit_nxt = (PW+2)'({2'h0, base_dev_r})
                     + (PW+2)'((25'(dyn_corr_r) * 25'(imax_r)) >> supervision_pkg::KD_FRAC); // RULE_03

  // stage 2: scaled mismatch phasor and scaled limit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stage2_r <= 1'b0;
      mis_re_r <= '0;
      mis_im_r <= '0;
      limit_sc_r <= '0;
      limit_r <= '0;
    end else begin
      stage2_r <= stage1_r;
      if (stage1_r) begin
        mis_re_r <= WW'(sum_re_r) * WW'($signed(ph_scale))
                    + WW'(earth_r.re) * WW'($signed(e_scale)); // RULE_01
        mis_im_r <= WW'(sum_im_r) * WW'($signed(ph_scale))
                    + WW'(earth_r.im) * WW'($signed(e_scale)); // RULE_01
        limit_sc_r <= MW'(limit_nxt) * MW'(ph_scale); // RULE_04
        limit_r <= limit_nxt; // RULE_03
      end
    end
  end

  assign mis_mag = supervision_pkg::mag_est(mis_re_r, mis_im_r); // RULE_01

  // stage 3: alarm follows every evaluation; disabled supervision holds it off
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alarm_r <= 1'b0;
    end else if (!ctrl_r[supervision_pkg::CTRL_ENABLE_BIT]) begin
      alarm_r <= 1'b0; // RULE_06
    end else if (stage2_r) begin
      alarm_r <= mis_mag >= limit_sc_r; // RULE_05 RULE_11
    end
  end

  // one rotation checker per input; the last input is the voltage set
  for (genvar g = 0; g < NI; g++) begin : g_rot
    rotation_check u_rot (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .seq_valid_i(seq_valid_i),
      .seq_i(seq_i[g]),
      .rated_i((g < supervision_pkg::NUM_CT) ? ct_rated_r : vt_rated_r), // RULE_09
      .reverse_set_i(ctrl_r[supervision_pkg::CTRL_REVERSE_BIT]),
      .forward_o(fwd[g]),
      .warn_o(warn[g])
    );
  end

  // rising edges of the alarm and each warning are interrupt events
  assign evt_now = {warn, alarm_r};
  assign evt_rise = evt_now & ~evt_prev_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_prev_r <= '0;
    end else begin
      evt_prev_r <= evt_now;
    end
  end

  // sticky status, write one to clear; a new event in the clear cycle survives
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_r <= '0;
    end else if (wr_hit && addr_i == supervision_pkg::IRQ_STAT_OFFS) begin
      irq_stat_r <= (irq_stat_r & ~wr_data_i[EW-1:0]) | evt_rise;
    end else begin
      irq_stat_r <= irq_stat_r | evt_rise;
    end
  end

  // interrupt mask, same layout as the status
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_r <= '0;
    end else if (wr_hit && addr_i == supervision_pkg::IRQ_MASK_OFFS) begin
      irq_mask_r <= wr_data_i[EW-1:0];
    end
  end

  // level interrupt, registered so the pin comes from a flip-flop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_r & irq_mask_r);
    end
  end

  // indication outputs, one cycle behind their sources
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alarm_o <= 1'b0;
      warn_o <= '0;
    end else begin
      alarm_o <= alarm_r; // RULE_05
      warn_o <= warn; // RULE_08
    end
  end

  // read decode; unmapped addresses read zero
  always_comb begin
    rd_nxt = '0;
    case (addr_i)
      supervision_pkg::CTRL_OFFS: begin
        rd_nxt[1:0] = ctrl_r;
      end
      supervision_pkg::BASE_DEV_OFFS: begin
        rd_nxt[15:0] = base_dev_r;
      end
      supervision_pkg::DYN_CORR_OFFS: begin
        rd_nxt[7:0] = dyn_corr_r;
      end
      supervision_pkg::PH_PRI_OFFS: begin
        rd_nxt[15:0] = ph_pri_r;
      end
      supervision_pkg::PH_SEC_OFFS: begin
        rd_nxt[15:0] = ph_sec_r;
      end
      supervision_pkg::E_PRI_OFFS: begin
        rd_nxt[15:0] = e_pri_r;
      end
      supervision_pkg::E_SEC_OFFS: begin
        rd_nxt[15:0] = e_sec_r;
      end
      supervision_pkg::CT_RATED_OFFS: begin
        rd_nxt[15:0] = ct_rated_r;
      end
      supervision_pkg::VT_RATED_OFFS: begin
        rd_nxt[15:0] = vt_rated_r;
      end
      supervision_pkg::STATUS_OFFS: begin
        rd_nxt[supervision_pkg::STAT_ALARM_BIT] = alarm_r;
        rd_nxt[supervision_pkg::STAT_WARN_LSB +: NI] = warn;
        rd_nxt[supervision_pkg::STAT_FWD_LSB +: NI] = fwd;
      end
      supervision_pkg::IRQ_STAT_OFFS: begin
        rd_nxt[EW-1:0] = irq_stat_r;
      end
      supervision_pkg::IRQ_MASK_OFFS: begin
        rd_nxt[EW-1:0] = irq_mask_r;
      end
      supervision_pkg::LIMIT_OFFS: begin
        rd_nxt[PW+1:0] = limit_r;
      end
      supervision_pkg::IMAX_OFFS: begin
        rd_nxt[PW:0] = imax_r;
      end
      default: begin
        rd_nxt = '0;
      end
    endcase
  end

  // read data stand only in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_o <= '0;
    end else if (rd_i) begin
      rd_data_o <= rd_nxt;
    end else begin
      rd_data_o <= '0;
    end
  end

endmodule

`default_nettype wire

// ==== logic/rotation_check.sv ====
// rotation detector and mismatch warning for one measuring input
`timescale 1ns/10ps
`default_nettype none

module rotation_check (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // sequence components of this input
  input wire logic seq_valid_i,
  input wire supervision_pkg::seq_type seq_i,
  // configuration
  input wire logic [supervision_pkg::RAT_W-1:0] rated_i,
  input wire logic reverse_set_i,
  // verdict
  output logic forward_o,
  output logic warn_o
);

  logic level_ok;
  logic fwd_now;

  // comparing pos*10 against rated avoids a divider
  assign level_ok = ({4'h0, seq_i.pos} * supervision_pkg::LEVEL_DIV) >= {4'h0, rated_i}; // RULE_09
  // positive sequence dominating means forward rotation
  assign fwd_now = seq_i.pos >= seq_i.neg; // RULE_07

  // detected rotation; held while the level is too low for a reliable verdict
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      forward_o <= 1'b1;
    end else if (seq_valid_i && level_ok) begin // RULE_09
      forward_o <= fwd_now; // RULE_07
    end
  end

  // warning when the detected rotation disagrees with the setting
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      warn_o <= 1'b0;
    end else if (seq_valid_i && level_ok) begin
      warn_o <= fwd_now == reverse_set_i; // RULE_08
    end
  end

endmodule

`default_nettype wire

// ==== tb/ct_source.sv ====
// model of the current and voltage measuring inputs
`timescale 1ns/10ps
`default_nettype none

module ct_source (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // commands from the bench
  input wire logic go_i,
  input wire logic signed [15:0] amp_i,
  input wire logic signed [15:0] earth_i,
  input wire logic seq_go_i,
  input wire supervision_pkg::seq_type [2:0] seq_cmd_i,
  // measuring inputs of the block
  output logic sample_valid_o,
  output supervision_pkg::cts_sample_type sample_o,
  output logic seq_valid_o,
  output supervision_pkg::seq_type [2:0] seq_o
);
  // three phases and a separate earth input always present; idle lines toggle
  always_ff @(posedge clk_i) begin
    sample_valid_o <= go_i && !rst_i;
    seq_valid_o <= seq_go_i && !rst_i;
    if (rst_i) begin
      sample_o <= '0;
      seq_o <= '0;
    end else begin
      sample_o <= go_i ? {amp_i, 16'h0, -(amp_i >>> 1), 16'h0, -(amp_i >>> 1), 16'h0,
                          earth_i, 16'h0} : ~sample_o;
      seq_o <= seq_go_i ? seq_cmd_i : ~seq_o;
    end
  end
endmodule

`default_nettype wire

// ==== tb/meas_chk.sv ====
// port assertions for the measuring circuit supervision
`timescale 1ns/10ps
`default_nettype none

module meas_chk (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [supervision_pkg::ADDR_W-1:0] addr_i,
  input wire logic [supervision_pkg::DATA_W-1:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [supervision_pkg::DATA_W-1:0] rd_data_o,
  // measuring inputs
  input wire logic sample_valid_i,
  input wire supervision_pkg::cts_sample_type sample_i,
  input wire logic seq_valid_i,
  input wire supervision_pkg::seq_type [supervision_pkg::NUM_IN-1:0] seq_i,
  // indications
  input wire logic alarm_o,
  input wire logic [supervision_pkg::NUM_IN-1:0] warn_o,
  input wire logic irq_o
);
  logic rev_r;
  logic en_r;
  logic [3:0] mask_r;

  // shadow of control and mask, so no internal probes are needed
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rev_r <= 1'b0;
      en_r <= 1'b0;
      mask_r <= 4'h0;
    end else if (wr_i && addr_i == supervision_pkg::CTRL_OFFS) begin
      rev_r <= wr_data_i[supervision_pkg::CTRL_REVERSE_BIT];
      en_r <= wr_data_i[supervision_pkg::CTRL_ENABLE_BIT];
    end else if (wr_i && addr_i == supervision_pkg::IRQ_MASK_OFFS) begin
      mask_r <= wr_data_i[3:0];
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_seq_big;
    seq_valid_i && seq_i[0].pos >= 16'h1000;
  endsequence
  sequence s_alarm_up;
    $rose(alarm_o) && mask_r[0];
  endsequence

  property p_alarm_cause;
    $changed(alarm_o) |-> $past(sample_valid_i, 4) || $past(wr_i) || $past(wr_i, 2) || $past(wr_i, 3);
  endproperty
  a_alarm_cause: assert property (p_alarm_cause) else $error("alarm moved without cause");
  property p_warn_cause;
    $changed(warn_o) |-> $past(seq_valid_i, 2);
  endproperty
  a_warn_cause: assert property (p_warn_cause) else $error("warning moved without cause");
  property p_low_level;
    seq_valid_i && seq_i[0].pos == 16'h0 && seq_i[1].pos == 16'h0 && seq_i[2].pos == 16'h0
      |-> ##2 $stable(warn_o);
  endproperty
  a_low_level: assert property (p_low_level) else $error("weak input changed a warning");
  property p_fwd;
    logic w;
    (s_seq_big, w = (seq_i[0].neg > seq_i[0].pos) != rev_r) |-> ##2 warn_o[0] == w;
  endproperty
  a_fwd: assert property (p_fwd) else $error("rotation verdict wrong");
  property p_zero;
    sample_valid_i && sample_i == 128'h0 |-> ##4 !alarm_o;
  endproperty
  a_zero: assert property (p_zero) else $error("alarm on a clean sample");
  property p_big;
    sample_valid_i && en_r && sample_i.ph1 == 32'h0 && sample_i.ph2 == 32'h0
      && sample_i.ph3 == 32'h0 && sample_i.earth.re == 16'sh7fff |-> ##4 alarm_o;
  endproperty
  a_big: assert property (p_big) else $error("no alarm on full earth mismatch");
  property p_irq;
    s_alarm_up |-> ##[0:2] irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing after alarm");
  property p_mask;
    $past(mask_r) == 4'h0 && mask_r == 4'h0 |-> !irq_o;
  endproperty
  a_mask: assert property (p_mask) else $error("interrupt while fully masked");
  property p_dis;
    wr_i && addr_i == supervision_pkg::CTRL_OFFS && !wr_data_i[0] |-> ##[1:3] !alarm_o;
  endproperty
  a_dis: assert property (p_dis) else $error("alarm kept after disable");
endmodule

`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench for the measuring circuit supervision
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end

module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [31:0] rd_data;
  logic go = 1'b0;
  logic seq_go = 1'b0;
  logic signed [15:0] amp = 16'sh0;
  logic signed [15:0] earth = 16'sh0;
  logic signed [15:0] ra = 16'sh0;
  logic signed [15:0] re = 16'sh0;
  supervision_pkg::seq_type [2:0] seq_cmd = '0;
  logic sample_valid;
  supervision_pkg::cts_sample_type sample;
  logic seq_valid;
  supervision_pkg::seq_type [2:0] seq;
  logic alarm;
  logic [2:0] warn;
  logic irq;
  logic [2:0] exp_warn = 3'h0;
  logic [15:0] lf = 16'h85a8;
  int errors = 0;
  int n_tests = 0;
  int kd = 0;
  int rt = 1;
  // rows of {pos, neg} for inputs 0..2; on inputs 0 and 2 row 2 sits just below one tenth of rated, row 3 just above; row 4 at zero
  logic [15:0] tv [0:5][0:5] = '{
    '{16'h200, 16'h100, 16'h200, 16'h100, 16'h400, 16'h100},
    '{16'h200, 16'h100, 16'h100, 16'h200, 16'h400, 16'h100},
    '{16'h199, 16'h1f4, 16'h200, 16'h100, 16'h333, 16'h384},
    '{16'h19a, 16'h1f4, 16'h200, 16'h100, 16'h334, 16'h384},
    '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0},
    '{16'h1000, 16'h2000, 16'h200, 16'h100, 16'h400, 16'h100}};

  always #5 clk_i = ~clk_i;

  ct_source src (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .amp_i(amp), .earth_i(earth),
    .seq_go_i(seq_go), .seq_cmd_i(seq_cmd), .sample_valid_o(sample_valid),
    .sample_o(sample), .seq_valid_o(seq_valid), .seq_o(seq));
  meas_supervision DUT (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr), .wr_data_i(wdat),
    .wr_i(wr_s), .rd_i(rd_s), .rd_data_o(rd_data), .sample_valid_i(sample_valid),
    .sample_i(sample), .seq_valid_i(seq_valid), .seq_i(seq), .alarm_o(alarm),
    .warn_o(warn), .irq_o(irq));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // limit grows with the largest phase; ratio scales the needed earth mismatch
  function automatic logic exp_al(input int a, input int e);
    int lim;
    lim = 256 + ((kd * a) >>> 8);
    exp_al = ((e < 0) ? -e : e) >= rt * lim;
  endfunction
  function automatic logic exp_w(input logic [15:0] p, input logic [15:0] n,
                                 input logic [15:0] r, input logic rev, input logic old);
    exp_w = (p * 10 >= r) ? ((n > p) != rev) : old;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr <= a;
    wdat <= d;
    wr_s <= 1'b1;
    @(posedge clk_i);
    wr_s <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_i);
    rd_s <= 1'b0;
    #1;
    `CHK(rd_data, e)
  endtask
  task automatic shot(input logic signed [15:0] a, input logic signed [15:0] e);
    @(posedge clk_i);
    amp <= a;
    earth <= e;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (5) @(posedge clk_i);
    #1;
    `CHK(alarm, exp_al(a, e))
  endtask
  task automatic rot(input int r);
    @(posedge clk_i);
    for (int k = 0; k < 3; k++) begin
      seq_cmd[k].pos <= tv[r][2*k];
      seq_cmd[k].neg <= tv[r][2*k+1];
      exp_warn[k] = exp_w(tv[r][2*k], tv[r][2*k+1], (k == 2) ? 16'h2000 : 16'h1000,
                          r == 5, exp_warn[k]);
    end
    seq_go <= 1'b1;
    @(posedge clk_i);
    seq_go <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    `CHK(warn, exp_warn)
  endtask
  task automatic complete_run;
    $display("errors %0d comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // a hang far beyond the expected few hundred cycles ends the run
  initial begin
    #300000;
    errors++;
    complete_run;
  end

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(supervision_pkg::CTRL_OFFS, 32'h0);
    rdc(supervision_pkg::BASE_DEV_OFFS, 32'h100);
    rdc(supervision_pkg::DYN_CORR_OFFS, 32'h0);
    rdc(supervision_pkg::E_SEC_OFFS, 32'h1);
    rdc(supervision_pkg::CT_RATED_OFFS, 32'h1000);
    rdc(supervision_pkg::STATUS_OFFS, 32'h700);
    rdc(8'hfc, 32'h0);
    wr(supervision_pkg::PH_PRI_OFFS, 32'h0);
    rdc(supervision_pkg::PH_PRI_OFFS, 32'h1);
    wr(supervision_pkg::CTRL_OFFS, 32'h1);
    wr(supervision_pkg::IRQ_MASK_OFFS, 32'h1);
    shot(16'sh0, 16'sh100);
    shot(16'sh0, 16'sh0ff);
    shot(16'sh0, -16'sh100);
    `CHK(irq, 1'b1)
    rdc(supervision_pkg::IRQ_STAT_OFFS, 32'h1);
    wr(supervision_pkg::IRQ_MASK_OFFS, 32'h0);
    repeat (2) @(posedge clk_i);
    #1;
    `CHK(irq, 1'b0)
    wr(supervision_pkg::IRQ_MASK_OFFS, 32'h1);
    wr(supervision_pkg::IRQ_STAT_OFFS, 32'h1);
    repeat (2) @(posedge clk_i);
    #1;
    `CHK(irq, 1'b0)
    shot(16'sh0, 16'sh0);
    shot(16'sh0, 16'sh7fff);
    wr(supervision_pkg::DYN_CORR_OFFS, 32'h80);
    kd = 128;
    shot(16'sh800, 16'sh500);
    shot(16'sh800, 16'sh4ff);
    rdc(supervision_pkg::LIMIT_OFFS, 32'h500);
    rdc(supervision_pkg::IMAX_OFFS, 32'h800);
    wr(supervision_pkg::PH_PRI_OFFS, 32'h2);
    rt = 2;
    shot(16'sh0, 16'sh200);
    shot(16'sh0, 16'sh1ff);
    wr(supervision_pkg::PH_PRI_OFFS, 32'h1);
    rt = 1;
    // random loads and mismatches around the moving limit
    for (int i = 0; i < 16; i++) begin
      lf = lfsr(lf);
      ra = lf & 16'h7ffe;
      lf = lfsr(lf);
      re = lf & 16'h7fff;
      shot(ra, re);
    end
    shot(16'sh0, 16'sh7fff);
    wr(supervision_pkg::CTRL_OFFS, 32'h0);
    repeat (3) @(posedge clk_i);
    #1;
    `CHK(alarm, 1'b0)
    wr(supervision_pkg::VT_RATED_OFFS, 32'h2000);
    for (int r = 0; r < 6; r++) begin
      if (r == 5) begin
        wr(supervision_pkg::CTRL_OFFS, 32'h2);
      end
      rot(r);
    end
    rdc(supervision_pkg::STATUS_OFFS, 32'h60c);
    complete_run;
  end
endmodule

bind meas_supervision meas_chk chk (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
  .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
  .sample_valid_i(sample_valid_i), .sample_i(sample_i), .seq_valid_i(seq_valid_i),
  .seq_i(seq_i), .alarm_o(alarm_o), .warn_o(warn_o), .irq_o(irq_o));

`default_nettype wire
